/* core/stop_reaction_pkg.sv */
// constants, register map and carrier types for the stop reaction selector
// assumes a classic wishbone slave with 32-bit data, one register per word
// Notes on behaviour
// - quick-stop code, reset 2, acts on quick-stop entry
// - quick-stop 0: stop now, go switch-on-disabled
// - codes 1/2: mode/quick ramp, then switch-on-disabled
// - codes 5/6: ramp, stay quick-stop, stay energized
// - shutdown code, reset 1, on enabled to ready
// - shutdown 0 coasts, 1 ramps to ready
// - disable code, reset 1, on enabled to switched-on
// - disable 0 coasts, 1 ramps to switched-on
// - halt bit 8 brakes per halt code
// - fault code: 0 coast, 1 mode, 2 quick ramp
// - decode signed mode request into mode enum
package stop_reaction_pkg;

  // register indices are word numbers: byte address is index*4
  localparam logic [15:0] IDX_QUICK_STOP = 16'h605a;
  localparam logic [15:0] IDX_SHUTDOWN   = 16'h605b;
  localparam logic [15:0] IDX_DISABLE    = 16'h605c;
  localparam logic [15:0] IDX_HALT       = 16'h605d;
  localparam logic [15:0] IDX_FAULT      = 16'h605e;
  localparam logic [15:0] IDX_MODE_REQ   = 16'h6060;
  localparam logic [15:0] IDX_CONTROL    = 16'h6040;
  localparam logic [15:0] IDX_STATUS     = 16'h6041;

  localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
  localparam logic [15:0] RST_SHUTDOWN   = 16'h0001;
  localparam logic [15:0] RST_DISABLE    = 16'h0001;
  localparam logic [15:0] RST_HALT       = 16'h0001;
  localparam logic [15:0] RST_FAULT      = 16'h0002;
  localparam logic [7:0]  RST_MODE_REQ   = 8'h00;

  localparam int HALT_BIT = 8;

  // status register field positions
  localparam int ST_ACTION_LSB = 0;
  localparam int ST_TARGET_LSB = 4;
  localparam int ST_ACTIVE_BIT = 8;
  localparam int ST_MODE_LSB   = 12;

  typedef enum logic [2:0]
  {
    ACT_NONE      = 3'h0,
    ACT_STOP_NOW  = 3'h1,
    ACT_COAST     = 3'h2,
    ACT_MODE_RAMP = 3'h3,
    ACT_QS_RAMP   = 3'h4
  } action_e;

  // power state to enter once the motor is at rest
  typedef enum logic [2:0]
  {
    PS_KEEP          = 3'h0,
    PS_SWITCH_ON_DIS = 3'h1,
    PS_READY         = 3'h3,
    PS_SWITCHED_ON   = 3'h2,
    PS_QUICK_STOP    = 3'h6
  } power_target_e;

  typedef enum logic [3:0]
  {
    MD_NONE      = 4'h0,
    MD_AUTOSETUP = 4'h1,
    MD_CLKDIR    = 4'h2,
    MD_PP        = 4'h3,
    MD_VL        = 4'h4,
    MD_PV        = 4'h5,
    MD_PT        = 4'h6,
    MD_HOME      = 4'h7,
    MD_IP        = 4'h8,
    MD_CSP       = 4'h9,
    MD_CSV       = 4'ha,
    MD_CST       = 4'hb,
    MD_RESERVED  = 4'hf
  } drive_mode_e;

  typedef struct packed
  {
    logic quick_stop_entry;
    logic shutdown_trans;
    logic disable_trans;
    logic fault;
  } events_s;

  typedef struct packed
  {
    action_e       action;
    power_target_e target;
    logic          keep_energized;
    logic          active;
  } reaction_s;

endpackage

/* core/stop_reaction_selector.sv */
// stop reaction selector: option codes, halt, mode request decode, wishbone slave
// assumes power-state events are single-cycle pulses from the power state machine
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module stop_reaction_selector
  import stop_reaction_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire events_s     events_i,
  input  wire logic        at_rest_i,
  output var reaction_s    reaction_o,
  output var drive_mode_e  mode_o
);

  logic [15:0] quick_stop_r;
  logic [15:0] shutdown_r;
  logic [15:0] disable_r;
  logic [15:0] halt_r;
  logic [15:0] fault_r;
  logic [7:0]  mode_req_r;
  logic [15:0] control_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [15:0] idx;
  logic        req;
  logic        wr;
  logic [15:0] wval;
  reaction_s   pick;
  reaction_s   react_r;
  drive_mode_e mode_r;
  logic        halt_pick;
  logic        halt_held;

  assign idx  = wb_adr_i[17:2];
  assign req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr   = req && wb_we_i;
  assign wval = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

  function automatic logic qs_ok(input logic [15:0] v);
    qs_ok = (v == 16'h0000) || (v == 16'h0001) || (v == 16'h0002)
         || (v == 16'h0005) || (v == 16'h0006);
  endfunction

  function automatic logic ramp_ok(input logic [15:0] v);
    ramp_ok = (v == 16'h0001) || (v == 16'h0002);
  endfunction

  function automatic logic coast_ok(input logic [15:0] v);
    coast_ok = (v == 16'h0000) || (v == 16'h0001);
  endfunction

  // single-wait-state slave; ack drops the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // code registers; a half-word write needs both low byte lanes to be meaningful
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      quick_stop_r <= RST_QUICK_STOP;
      shutdown_r   <= RST_SHUTDOWN;
      disable_r    <= RST_DISABLE;
      halt_r       <= RST_HALT;
      fault_r      <= RST_FAULT;
      mode_req_r   <= RST_MODE_REQ;
      control_r    <= 16'h0000;
    end
    else if (wr)
    begin
      if (idx == IDX_QUICK_STOP)
      begin
        if (qs_ok(wval))
          quick_stop_r <= wval;
      end
      else if (idx == IDX_SHUTDOWN)
      begin
        if (coast_ok(wval))
          shutdown_r <= wval;
      end
      else if (idx == IDX_DISABLE)
      begin
        if (coast_ok(wval))
          disable_r <= wval;
      end
      else if (idx == IDX_HALT)
      begin
        if (ramp_ok(wval))
          halt_r <= wval;
      end
      else if (idx == IDX_FAULT)
      begin
        if (coast_ok(wval) || ramp_ok(wval))
          fault_r <= wval;
      end
      else if (idx == IDX_MODE_REQ)
      begin
        if (wb_sel_i[0])
          mode_req_r <= wb_dat_i[7:0];
      end
      else if (idx == IDX_CONTROL)
      begin
        control_r <= wval;
      end
    end
  end

  // mode request decode
  always_comb
  begin
    case (mode_req_r)
      8'hfe:   mode_r = MD_AUTOSETUP;
      8'hff:   mode_r = MD_CLKDIR;
      8'h00:   mode_r = MD_NONE;
      8'h01:   mode_r = MD_PP;
      8'h02:   mode_r = MD_VL;
      8'h03:   mode_r = MD_PV;
      8'h04:   mode_r = MD_PT;
      8'h06:   mode_r = MD_HOME;
      8'h07:   mode_r = MD_IP;
      8'h08:   mode_r = MD_CSP;
      8'h09:   mode_r = MD_CSV;
      8'h0a:   mode_r = MD_CST;
      default: mode_r = MD_RESERVED;
    endcase
  end

  // event priority: fault, quick stop, shutdown, disable, then halt
  always_comb
  begin
    pick = '{action: ACT_NONE, target: PS_KEEP, keep_energized: 1'b0, active: 1'b0};
    if (events_i.fault)
    begin
      pick.active = 1'b1;
      case (fault_r)
        16'h0000: pick.action = ACT_COAST;
        16'h0001: pick.action = ACT_MODE_RAMP;
        default:  pick.action = ACT_QS_RAMP;
      endcase
    end
    else if (events_i.quick_stop_entry)
    begin
      pick.active = 1'b1;
      case (quick_stop_r)
        16'h0000:
        begin
          pick.action = ACT_STOP_NOW;
          pick.target = PS_SWITCH_ON_DIS;
        end
        16'h0001:
        begin
          pick.action = ACT_MODE_RAMP;
          pick.target = PS_SWITCH_ON_DIS;
        end
        16'h0005:
        begin
          pick.action         = ACT_MODE_RAMP;
          pick.target         = PS_QUICK_STOP;
          pick.keep_energized = 1'b1;
        end
        16'h0006:
        begin
          pick.action         = ACT_QS_RAMP;
          pick.target         = PS_QUICK_STOP;
          pick.keep_energized = 1'b1;
        end
        default:
        begin
          pick.action = ACT_QS_RAMP;
          pick.target = PS_SWITCH_ON_DIS;
        end
      endcase
    end
    else if (events_i.shutdown_trans)
    begin
      pick.active = 1'b1;
      pick.target = PS_READY;
      pick.action = (shutdown_r == 16'h0000) ? ACT_COAST : ACT_MODE_RAMP;
    end
    else if (events_i.disable_trans)
    begin
      pick.active = 1'b1;
      pick.target = PS_SWITCHED_ON;
      pick.action = (disable_r == 16'h0000) ? ACT_COAST : ACT_MODE_RAMP;
    end
    else if (control_r[HALT_BIT])
    begin
      pick.active         = 1'b1;
      pick.keep_energized = 1'b1;
      pick.action = (halt_r == 16'h0002) ? ACT_QS_RAMP : ACT_MODE_RAMP;
    end
  end

  // fault also has no target, so halt is told apart by the energized flag
  assign halt_pick = pick.target == PS_KEEP && pick.keep_energized;
  assign halt_held = react_r.active && react_r.target == PS_KEEP && react_r.keep_energized;

  // a started reaction is held until the motor reports rest, one with the quick-stop target beyond that; halt follows the bit level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      react_r <= '{action: ACT_NONE, target: PS_KEEP, keep_energized: 1'b0, active: 1'b0};
    else if (pick.active && (!halt_pick || !react_r.active || halt_held))
      react_r <= pick;
    else if (halt_held && !control_r[HALT_BIT])
      react_r <= '0;
    else if (react_r.active && !halt_held && at_rest_i && react_r.target != PS_QUICK_STOP)
      react_r <= '0;
  end

  // read mux; unmapped indices read zero and still acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      if (idx == IDX_QUICK_STOP)
        rdata_r <= {{16{quick_stop_r[15]}}, quick_stop_r};
      else if (idx == IDX_SHUTDOWN)
        rdata_r <= {{16{shutdown_r[15]}}, shutdown_r};
      else if (idx == IDX_DISABLE)
        rdata_r <= {{16{disable_r[15]}}, disable_r};
      else if (idx == IDX_HALT)
        rdata_r <= {{16{halt_r[15]}}, halt_r};
      else if (idx == IDX_FAULT)
        rdata_r <= {{16{fault_r[15]}}, fault_r};
      else if (idx == IDX_MODE_REQ)
        rdata_r <= {{24{mode_req_r[7]}}, mode_req_r};
      else if (idx == IDX_CONTROL)
        rdata_r <= {16'h0000, control_r};
      else if (idx == IDX_STATUS)
        rdata_r <= {16'h0000, mode_r, 3'h0, react_r.active, 1'b0, react_r.target,
                    1'b0, react_r.action};
      else
        rdata_r <= 32'h0000_0000;
    end
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdata_r;
  assign reaction_o = react_r;
  assign mode_o     = mode_r;

  property p_refuse_reserved;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_HALT && !ramp_ok(wval)) |=> $stable(halt_r);
  endproperty
  a_refuse_reserved: assert property (p_refuse_reserved) else $error("reserved halt");

  property p_qs_zero;
    @(posedge clk_i) disable iff (rst_i)
    (events_i.fault == 1'b0 && events_i.quick_stop_entry && quick_stop_r == 16'h0000)
      |=> (reaction_o.action == ACT_STOP_NOW && reaction_o.target == PS_SWITCH_ON_DIS);
  endproperty
  a_qs_zero: assert property (p_qs_zero) else $error("quick stop 0 not immediate");

  property p_qs_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!events_i.fault && events_i.quick_stop_entry && quick_stop_r == 16'h0006)
      |=> (reaction_o.keep_energized && reaction_o.target == PS_QUICK_STOP
           && reaction_o.action == ACT_QS_RAMP);
  endproperty
  a_qs_hold: assert property (p_qs_hold) else $error("quick stop 6 wrong");

  property p_fault_coast;
    @(posedge clk_i) disable iff (rst_i)
    (events_i.fault && fault_r == 16'h0000) |=> (reaction_o.action == ACT_COAST);
  endproperty
  a_fault_coast: assert property (p_fault_coast) else $error("fault 0 did not coast");

  property p_shutdown_target;
    @(posedge clk_i) disable iff (rst_i)
    (events_i == 4'b0100) |=> (reaction_o.target == PS_READY && reaction_o.active);
  endproperty
  a_shutdown_target: assert property (p_shutdown_target) else $error("bad shutdown");

  property p_disable_ramp;
    @(posedge clk_i) disable iff (rst_i)
    (events_i == 4'b0010 && disable_r == 16'h0001)
      |=> (reaction_o.action == ACT_MODE_RAMP && reaction_o.target == PS_SWITCHED_ON);
  endproperty
  a_disable_ramp: assert property (p_disable_ramp) else $error("disable 1 wrong");

  property p_halt_quick;
    @(posedge clk_i) disable iff (rst_i)
    (events_i == 4'b0000 && control_r[HALT_BIT] && halt_r == 16'h0002 && !react_r.active)
      |=> (reaction_o.action == ACT_QS_RAMP);
  endproperty
  a_halt_quick: assert property (p_halt_quick) else $error("halt 2 wrong ramp");

  property p_mode_decode;
    @(posedge clk_i) disable iff (rst_i)
    (mode_req_r == 8'hfe) |-> (mode_o == MD_AUTOSETUP);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode -2 misdecoded");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_qs_one;
    @(posedge clk_i) disable iff (rst_i)
    (!events_i.fault && events_i.quick_stop_entry && quick_stop_r == 16'h0001)
      |=> (reaction_o.action == ACT_MODE_RAMP && reaction_o.target == PS_SWITCH_ON_DIS);
  endproperty
  a_qs_one: assert property (p_qs_one) else $error("quick stop 1 wrong");

  property p_shutdown_coast;
    @(posedge clk_i) disable iff (rst_i)
    (events_i == 4'b0100 && shutdown_r == 16'h0000) |=> (reaction_o.action == ACT_COAST);
  endproperty
  a_shutdown_coast: assert property (p_shutdown_coast) else $error("no coast");

  // halt must end as soon as the control bit is cleared
  property p_halt_release;
    @(posedge clk_i) disable iff (rst_i)
    (halt_held && !control_r[HALT_BIT] && events_i == 4'b0000) |=> !reaction_o.active;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");

  property p_quick_stop_held;
    @(posedge clk_i) disable iff (rst_i)
    (react_r.active && react_r.target == PS_QUICK_STOP && at_rest_i && events_i == 4'b0000)
      |=> $stable(reaction_o);
  endproperty
  a_quick_stop_held: assert property (p_quick_stop_held) else $error("qs dropped");

  property p_refuse_qs;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_QUICK_STOP && !qs_ok(wval)) |=> $stable(quick_stop_r);
  endproperty
  a_refuse_qs: assert property (p_refuse_qs) else $error("reserved qs");

endmodule
`default_nettype wire

/* test/wb_master_model.sv */
// classic wishbone master standing in for the fieldbus master
// assumes the bench pulses req_i for one cycle only while cyc_o is low
`timescale 1ns/1ns
`default_nettype none
module wb_master_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic      [17:0] adr_o,
  output logic      [31:0] dat_o
);
  // one vector so every output has a value before the first edge
  logic [51:0] req_r = '0;

  assign {cyc_o, we_o, adr_o, dat_o} = req_r;

  // request held until ack is sampled, then cyc drops for a cycle at least
  always @(posedge clk_i)
    if (rst_i || (req_r[51] && ack_i))
      req_r[51] <= 1'b0;
    else if (req_i && !req_r[51])
      req_r <= {1'b1, we_i, adr_i, dat_i};
endmodule
`default_nettype wire

/* test/drive_stop_reaction_selector_bench.sv */
// self-checking bench for the stop reaction selector
// assumes the wishbone master model drives the slave port, stb tied to cyc
`timescale 1ns/1ns
`default_nettype none
module drive_stop_reaction_selector_bench
  import stop_reaction_pkg::*;
;
  typedef struct packed
  {
    logic [15:0] idx;
    logic [3:0]  code;
    logic [3:0]  ev;
    logic [11:0] st;
    logic [11:0] msk;
    logic        ke;
    logic        held;
  } entry_s;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  events_s     events_i = '0;
  logic        at_rest_i = 1'b0;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [17:0] adr = '0;
  logic [31:0] dat = '0;
  logic        cyc;
  logic        mwe;
  logic        ack;
  logic [17:0] madr;
  logic [31:0] mdat;
  logic [31:0] rdat;
  reaction_s   reaction_o;
  drive_mode_e mode_o;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] rnd = 32'h0000_0c5f;
  logic [15:0] v;
  logic [3:0]  xm;
  int          fail_count = 0;
  int          total_checks = 0;
  int          i;
  int          j;
  logic [15:0] regs [5] = '{IDX_QUICK_STOP, IDX_SHUTDOWN, IDX_DISABLE, IDX_HALT, IDX_FAULT};
  logic [15:0] rstv [5] = '{RST_QUICK_STOP, RST_SHUTDOWN, RST_DISABLE, RST_HALT, RST_FAULT};
  logic [3:0]  mtab [13] = '{4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf, 4'h7, 4'h8, 4'h9,
                             4'ha, 4'hb};
  // status masks leave out targets that the rules do not fix
  entry_s      tbl [14] = '{
    '{IDX_QUICK_STOP, 4'h0, 4'h8, 12'h111, 12'h177, 1'b0, 1'b0},
    '{IDX_QUICK_STOP, 4'h1, 4'h8, 12'h113, 12'h177, 1'b0, 1'b0},
    '{IDX_QUICK_STOP, 4'h2, 4'h8, 12'h114, 12'h177, 1'b0, 1'b0},
    '{IDX_QUICK_STOP, 4'h5, 4'h8, 12'h163, 12'h177, 1'b1, 1'b1},
    '{IDX_QUICK_STOP, 4'h6, 4'h8, 12'h164, 12'h177, 1'b1, 1'b1},
    '{IDX_SHUTDOWN,   4'h0, 4'h4, 12'h102, 12'h107, 1'b0, 1'b0},
    '{IDX_SHUTDOWN,   4'h1, 4'h4, 12'h133, 12'h177, 1'b0, 1'b0},
    '{IDX_DISABLE,    4'h0, 4'h2, 12'h102, 12'h107, 1'b0, 1'b0},
    '{IDX_DISABLE,    4'h1, 4'h2, 12'h123, 12'h177, 1'b0, 1'b0},
    '{IDX_HALT,       4'h1, 4'h0, 12'h103, 12'h107, 1'b1, 1'b0},
    '{IDX_HALT,       4'h2, 4'h0, 12'h104, 12'h107, 1'b1, 1'b0},
    '{IDX_FAULT,      4'h0, 4'h1, 12'h102, 12'h107, 1'b0, 1'b0},
    '{IDX_FAULT,      4'h1, 4'h1, 12'h103, 12'h107, 1'b0, 1'b0},
    '{IDX_FAULT,      4'h2, 4'h1, 12'h104, 12'h107, 1'b0, 1'b0}};

  always #2 clk_i = ~clk_i;

  wb_master_model host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .we_i(we), .adr_i(adr),
    .dat_i(dat), .ack_i(ack), .cyc_o(cyc), .we_o(mwe), .adr_o(madr), .dat_o(mdat));

  stop_reaction_selector dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(mwe), .wb_adr_i(madr), .wb_sel_i(4'hf), .wb_dat_i(mdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .events_i(events_i), .at_rest_i(at_rest_i), .reaction_o(reaction_o),
    .mode_o(mode_o));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic results;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] next_rnd();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  function automatic logic ok(input logic [15:0] idx, input logic [15:0] c);
    case (idx)
      IDX_QUICK_STOP: return c inside {16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
      IDX_SHUTDOWN, IDX_DISABLE: return c < 16'h0002;
      IDX_HALT: return c inside {16'h0001, 16'h0002};
      default: return c < 16'h0003;
    endcase
  endfunction

  function automatic logic [3:0] exp_mode(input logic signed [7:0] m);
    return (m >= -2 && m <= 10) ? mtab[m + 2] : 4'hf;
  endfunction

  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    @(posedge clk_i);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end while (cyc !== 1'b0 && n < 50);
    if (cyc !== 1'b0)
    begin
      fail_count++;
      results();
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x & m});
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i     <= 1'b1;
    at_rest_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // read data is judged against the oldest note while ack stands
  always @(negedge clk_i)
    if (ack === 1'b1 && mwe === 1'b0)
    begin
      e = exp_q.pop_front();
      check("wb_dat_o", rdat & e[63:32], e[31:0]);
    end

  initial
  begin
    do_reset();
    for (i = 0; i < 5; i++)
      rd(regs[i], {16'h0000, rstv[i]}, 32'hffff_ffff);
    bus(1'b1, 16'h605f, next_rnd());
    rd(16'h605f, 32'h0000_0000, 32'hffff_ffff);
    bus(1'b1, IDX_STATUS, 32'h0000_ffff);
    rd(IDX_STATUS, 32'h0000_0000, 32'hffff_ffff);
    for (i = 0; i < 5; i++)
      for (j = 0; j < 6; j++)
      begin
        v = (j == 0) ? 16'h7fff : (j == 1) ? 16'h8000 : 16'(next_rnd());
        if (!ok(regs[i], v))
        begin
          bus(1'b1, regs[i], {rnd[31:16], v});
          rd(regs[i], {16'h0000, rstv[i]}, 32'hffff_ffff);
        end
      end
    for (i = -4; i < 16; i++)
    begin
      v = (i < 13) ? 16'(i) : 16'(next_rnd());
      xm = exp_mode(v[7:0]);
      bus(1'b1, IDX_MODE_REQ, {24'h00_0000, v[7:0]});
      rd(IDX_STATUS, {16'h0000, xm, 12'h000}, 32'h0000_f000);
      rd(IDX_MODE_REQ, {{24{v[7]}}, v[7:0]}, 32'hffff_ffff);
      check("mode_o", {28'h000_0000, mode_o}, {28'h000_0000, xm});
    end
    for (i = 0; i < 14; i++)
    begin
      do_reset();
      bus(1'b1, tbl[i].idx, {28'h000_0000, tbl[i].code});
      rd(tbl[i].idx, {28'h000_0000, tbl[i].code}, 32'hffff_ffff);
      if (tbl[i].ev == 4'h0)
        bus(1'b1, IDX_CONTROL, 32'h0000_0100);
      else
      begin
        @(posedge clk_i);
        events_i <= events_s'(tbl[i].ev);
        @(posedge clk_i);
        events_i <= '0;
      end
      rd(IDX_STATUS, {20'h0_0000, tbl[i].st}, {20'h0_0000, tbl[i].msk});
      check("keep_energized", {31'h0, reaction_o.keep_energized}, {31'h0, tbl[i].ke});
      // halt ends by clearing the control bit, the others at standstill except quick-stop codes 5 and 6
      if (tbl[i].ev == 4'h0)
        bus(1'b1, IDX_CONTROL, 32'h0000_0000);
      else
      begin
        @(posedge clk_i);
        at_rest_i <= 1'b1;
      end
      repeat (3) @(posedge clk_i);
      rd(IDX_STATUS, {23'h0, tbl[i].held, 8'h00}, 32'h0000_0100);
    end
    results();
  end
endmodule
`default_nettype wire
